// ===== bus_responder.sv
// Bus-side model answering item requests after a set wait
`timescale 1ns/1ps
module bus_responder (
    input wire logic clk,
    input wire logic rst,
    input wire logic xfer_valid,
    input wire logic [3:0] delay,
    input wire logic fail,
    output logic xfer_ack,
    output logic bus_error
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            xfer_ack <= 1'b0;
            bus_error <= 1'b0;
        end else begin
            xfer_ack <= 1'b0;
            bus_error <= 1'b0;
            // One answer pulse per request, none while the last is seen
            if (xfer_valid && !xfer_ack && !bus_error) begin
                if (wait_cnt == delay) begin
                    xfer_ack <= !fail;
                    bus_error <= fail;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule

// ===== dma_chan_addr.sv
// Per-channel current address generator with stepping and base reload
`timescale 1ns/1ps
module dma_chan_addr (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [31:0] base,
    input wire logic step,
    input wire logic step_en,
    input wire logic [1:0] size,
    output logic [31:0] addr
);
    logic [31:0] inc;

    always_comb begin
        unique case (size)
            dma_ctl_pkg::SIZE_8: inc = dma_ctl_pkg::STEP_8;
            dma_ctl_pkg::SIZE_16: inc = dma_ctl_pkg::STEP_16;
            default: inc = dma_ctl_pkg::STEP_32;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr <= 32'h0;
        end else if (load) begin
            addr <= base;
        end else if (step && step_en) begin
            addr <= addr + inc;
        end
    end
endmodule

// ===== dma_ctl.sv
// Seven-channel DMA control and status registers with arbiter and counters
//
// Operation
// - Four status bits per channel, top reserved
// - Any-event flag set by any event
// - Done flag set at transfer end
// - Halfway flag set at half event
// - Error flag set on transfer error
// - All-clear bit wipes channel's four flags
// - Done clear bit clears done flag
// - Halfway clear bit clears halfway flag
// - Error clear bit clears error flag
// - Config bits 1-3 enable interrupts
// - Config bit 4 selects transfer direction
// - Bits 6,7 enable address stepping
// - Bits 9:8 peripheral item size
// - Bits 11:10 memory item size
// - Bits 13:12 software priority level
// - Bit 14 mem-to-mem, bit 5 circular
// - Count writable only while channel disabled
// - Count decrements per item, ends zero
// - Zero count means no transfers
// - Equal priority: lowest channel wins
// - Address steps by item size
// - Mem-to-mem starts without peripheral request
// - Circular reload restores base addresses
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module dma_ctl #(
    parameter int NUM_CHAN = dma_ctl_pkg::NUM_CHAN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_CHAN-1:0] periph_req,
    input wire logic xfer_ack,
    input wire logic bus_error,
    output logic xfer_valid,
    output logic [2:0] xfer_chan,
    output logic xfer_mem_to_periph,
    output logic [31:0] xfer_src_addr,
    output logic [31:0] xfer_dst_addr,
    output logic [1:0] xfer_src_size,
    output logic [1:0] xfer_dst_size,
    output logic [NUM_CHAN-1:0] chan_irq
);
    localparam int FW = dma_ctl_pkg::FLAG_W;
    localparam int CW = dma_ctl_pkg::CNT_W;

    logic [NUM_CHAN-1:0][dma_ctl_pkg::CFG_W-1:0] cfg;
    logic [NUM_CHAN-1:0][CW-1:0] remaining_count;
    logic [NUM_CHAN-1:0][CW-1:0] count_base;
    logic [NUM_CHAN-1:0][31:0] paddr_base;
    logic [NUM_CHAN-1:0][31:0] maddr_base;
    logic [NUM_CHAN-1:0][31:0] paddr_cur;
    logic [NUM_CHAN-1:0][31:0] maddr_cur;
    logic [NUM_CHAN-1:0][FW-1:0] flags;
    logic [NUM_CHAN-1:0] req_sync1;
    logic [NUM_CHAN-1:0] req_sync2;
    logic [NUM_CHAN-1:0] want;
    logic [NUM_CHAN-1:0] cfg_wr;
    logic [NUM_CHAN-1:0] cnt_wr;
    logic [NUM_CHAN-1:0] paddr_wr;
    logic [NUM_CHAN-1:0] maddr_wr;
    logic [NUM_CHAN-1:0] done_ev;
    logic [NUM_CHAN-1:0] half_ev;
    logic [NUM_CHAN-1:0] err_ev;
    logic [NUM_CHAN-1:0] item_ev;
    logic [NUM_CHAN-1:0] reload;
    logic clear_wr;
    logic busy;
    logic [2:0] grant;
    logic grant_ok;
    logic [2:0] next_grant;
    logic next_grant_ok;
    logic [31:0] next_rdata;

    // Pin-level peripheral requests cross into the clock domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_sync1 <= '0;
            req_sync2 <= '0;
        end else begin
            req_sync1 <= periph_req;
            req_sync2 <= req_sync1;
        end
    end

    assign clear_wr = reg_write && (reg_addr == dma_ctl_pkg::OFS_CLEAR);

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            cfg_wr[i] = reg_write &&
                (reg_addr == 8'(dma_ctl_pkg::OFS_CFG0 + i * dma_ctl_pkg::CHAN_STRIDE));
            cnt_wr[i] = reg_write &&
                (reg_addr == 8'(dma_ctl_pkg::OFS_CNT0 + i * dma_ctl_pkg::CHAN_STRIDE));
            paddr_wr[i] = reg_write &&
                (reg_addr == 8'(dma_ctl_pkg::OFS_PADDR0 + i * dma_ctl_pkg::CHAN_STRIDE));
            maddr_wr[i] = reg_write &&
                (reg_addr == 8'(dma_ctl_pkg::OFS_MADDR0 + i * dma_ctl_pkg::CHAN_STRIDE));
            want[i] = cfg[i][dma_ctl_pkg::CFG_EN] && (remaining_count[i] != '0) &&
                (cfg[i][dma_ctl_pkg::CFG_M2M] || req_sync2[i]);
        end
    end

    // Priority first, then lowest channel number
    always_comb begin
        logic [1:0] best;
        best = 2'h0;
        next_grant = 3'h0;
        next_grant_ok = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (want[i] && (!next_grant_ok ||
                    cfg[i][dma_ctl_pkg::CFG_PRIO +: 2] > best)) begin
                next_grant_ok = 1'b1;
                next_grant = 3'(i);
                best = cfg[i][dma_ctl_pkg::CFG_PRIO +: 2];
            end
        end
    end

    // One item in flight at a time; a grant holds until ack, error or the channel is disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            grant <= 3'h0;
            grant_ok <= 1'b0;
        end else if (busy) begin
            if (xfer_ack || bus_error || !cfg[grant][dma_ctl_pkg::CFG_EN]) begin
                busy <= 1'b0;
                grant_ok <= 1'b0;
            end
        end else if (next_grant_ok) begin
            busy <= 1'b1;
            grant <= next_grant;
            grant_ok <= 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            item_ev[i] = busy && grant_ok && (grant == 3'(i)) && xfer_ack && !bus_error;
            err_ev[i] = busy && grant_ok && (grant == 3'(i)) && bus_error;
            done_ev[i] = item_ev[i] && (remaining_count[i] == CW'(1));
            half_ev[i] = item_ev[i] && (remaining_count[i] - CW'(1) ==
                (count_base[i] >> 1)) && (count_base[i] > CW'(1));
            reload[i] = done_ev[i] && cfg[i][dma_ctl_pkg::CFG_CIRC];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (cfg_wr[i]) begin
                    cfg[i] <= reg_wdata[dma_ctl_pkg::CFG_W-1:0];
                end else if (err_ev[i]) begin
                    cfg[i][dma_ctl_pkg::CFG_EN] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remaining_count <= '0;
            count_base <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (cnt_wr[i] && !cfg[i][dma_ctl_pkg::CFG_EN]) begin
                    remaining_count[i] <= reg_wdata[CW-1:0];
                    count_base[i] <= reg_wdata[CW-1:0];
                end else if (reload[i]) begin
                    remaining_count[i] <= count_base[i];
                end else if (item_ev[i]) begin
                    remaining_count[i] <= remaining_count[i] - CW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            paddr_base <= '0;
            maddr_base <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (paddr_wr[i] && !cfg[i][dma_ctl_pkg::CFG_EN]) begin
                    paddr_base[i] <= reg_wdata;
                end
                if (maddr_wr[i] && !cfg[i][dma_ctl_pkg::CFG_EN]) begin
                    maddr_base[i] <= reg_wdata;
                end
            end
        end
    end

    for (genvar g = 0; g < NUM_CHAN; g++) begin : gen_addr
        logic load_a;
        assign load_a = reload[g] || (!cfg[g][dma_ctl_pkg::CFG_EN] && !busy);
        dma_chan_addr u_paddr (
            .clk(clk),
            .rst(rst),
            .load(load_a),
            .base(paddr_base[g]),
            .step(item_ev[g]),
            .step_en(cfg[g][dma_ctl_pkg::CFG_PINC]),
            .size(cfg[g][dma_ctl_pkg::CFG_PSIZE +: 2]),
            .addr(paddr_cur[g])
        );
        dma_chan_addr u_maddr (
            .clk(clk),
            .rst(rst),
            .load(load_a),
            .base(maddr_base[g]),
            .step(item_ev[g]),
            .step_en(cfg[g][dma_ctl_pkg::CFG_MINC]),
            .size(cfg[g][dma_ctl_pkg::CFG_MEM_ITEM_SIZE +: 2]),
            .addr(maddr_cur[g])
        );
    end

    // Events win over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                logic [FW-1:0] clr;
                logic [FW-1:0] set;
                clr = '0;
                set = '0;
                if (clear_wr) begin
                    clr = reg_wdata[i*FW +: FW];
                    if (reg_wdata[i*FW + dma_ctl_pkg::FLAG_ANY]) begin
                        clr = '1;
                    end
                end
                set[dma_ctl_pkg::FLAG_DONE] = done_ev[i];
                set[dma_ctl_pkg::FLAG_HALF] = half_ev[i];
                set[dma_ctl_pkg::FLAG_ERR] = err_ev[i];
                set[dma_ctl_pkg::FLAG_ANY] = done_ev[i] || half_ev[i] || err_ev[i];
                flags[i] <= (flags[i] & ~clr) | set;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_irq <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                chan_irq[i] <= (flags[i][dma_ctl_pkg::FLAG_DONE] &&
                        cfg[i][dma_ctl_pkg::CFG_DONE_IE]) ||
                    (flags[i][dma_ctl_pkg::FLAG_HALF] && cfg[i][dma_ctl_pkg::CFG_HALF_IE]) ||
                    (flags[i][dma_ctl_pkg::FLAG_ERR] && cfg[i][dma_ctl_pkg::CFG_ERR_IE]);
            end
        end
    end

    // Transfer request to the system bus side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_valid <= 1'b0;
            xfer_chan <= 3'h0;
            xfer_mem_to_periph <= 1'b0;
            xfer_src_addr <= 32'h0;
            xfer_dst_addr <= 32'h0;
            xfer_src_size <= 2'h0;
            xfer_dst_size <= 2'h0;
        end else begin
            xfer_valid <= busy && grant_ok && !xfer_ack && !bus_error &&
                cfg[grant][dma_ctl_pkg::CFG_EN];
            xfer_chan <= grant;
            xfer_mem_to_periph <= cfg[grant][dma_ctl_pkg::CFG_DIR];
            if (cfg[grant][dma_ctl_pkg::CFG_DIR]) begin
                xfer_src_addr <= maddr_cur[grant];
                xfer_dst_addr <= paddr_cur[grant];
                xfer_src_size <= cfg[grant][dma_ctl_pkg::CFG_MEM_ITEM_SIZE +: 2];
                xfer_dst_size <= cfg[grant][dma_ctl_pkg::CFG_PSIZE +: 2];
            end else begin
                xfer_src_addr <= paddr_cur[grant];
                xfer_dst_addr <= maddr_cur[grant];
                xfer_src_size <= cfg[grant][dma_ctl_pkg::CFG_PSIZE +: 2];
                xfer_dst_size <= cfg[grant][dma_ctl_pkg::CFG_MEM_ITEM_SIZE +: 2];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        if (reg_addr == dma_ctl_pkg::OFS_STATUS) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                next_rdata[i*FW +: FW] = flags[i];
            end
        end
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (reg_addr == 8'(dma_ctl_pkg::OFS_CFG0 + i * dma_ctl_pkg::CHAN_STRIDE)) begin
                next_rdata = {17'h0, cfg[i]};
            end
            if (reg_addr == 8'(dma_ctl_pkg::OFS_CNT0 + i * dma_ctl_pkg::CHAN_STRIDE)) begin
                next_rdata = {16'h0, remaining_count[i]};
            end
            if (reg_addr == 8'(dma_ctl_pkg::OFS_PADDR0 + i * dma_ctl_pkg::CHAN_STRIDE)) begin
                next_rdata = paddr_base[i];
            end
            if (reg_addr == 8'(dma_ctl_pkg::OFS_MADDR0 + i * dma_ctl_pkg::CHAN_STRIDE)) begin
                next_rdata = maddr_base[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule

// ===== dma_ctl_assertions.sv
// Port-level checks of the DMA control block
`timescale 1ns/1ps
module dma_ctl_assertions #(
    parameter int NUM_CHAN = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic xfer_ack,
    input wire logic bus_error,
    input wire logic xfer_valid,
    input wire logic [2:0] xfer_chan,
    input wire logic [31:0] xfer_src_addr,
    input wire logic [31:0] xfer_dst_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence item_wait;
        xfer_valid && !xfer_ack && !bus_error;
    endsequence
    sequence item_end;
        xfer_valid && (xfer_ack || bus_error);
    endsequence
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read");
    status_top_zero_a: assert property (
        reg_read && reg_addr == dma_ctl_pkg::OFS_STATUS |=> reg_rdata[31:28] == 4'h0)
        else $error("status top bits not zero");
    config_top_zero_a: assert property (
        reg_read && reg_addr == dma_ctl_pkg::OFS_CFG0 |=> reg_rdata[31:15] == 17'h0)
        else $error("config top bits not zero");
    count_top_zero_a: assert property (
        reg_read && reg_addr == dma_ctl_pkg::OFS_CNT0 |=> reg_rdata[31:16] == 16'h0)
        else $error("count top bits not zero");
    item_hold_a: assert property (item_wait |=> xfer_valid)
        else $error("item request dropped before answer");
    item_drop_a: assert property (item_end |=> !xfer_valid)
        else $error("item request held after answer");
    item_stable_a: assert property (item_wait |=> $stable(xfer_chan) &&
        $stable(xfer_src_addr) && $stable(xfer_dst_addr))
        else $error("item fields moved while waiting");
    chan_range_a: assert property (xfer_valid |-> int'(xfer_chan) < NUM_CHAN)
        else $error("granted channel out of range");
endmodule
bind dma_ctl dma_ctl_assertions #(.NUM_CHAN(NUM_CHAN)) i_chk (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .xfer_ack(xfer_ack),
    .bus_error(bus_error), .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
    .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr));

// ===== dma_ctl_pkg.sv
// Register map, field layout and item size and step constants of the DMA control block
package dma_ctl_pkg;
    localparam int NUM_CHAN = 7;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CLEAR = 8'h04;
    localparam logic [7:0] OFS_CFG0 = 8'h08;
    localparam logic [7:0] OFS_CNT0 = 8'h0c;
    localparam logic [7:0] OFS_PADDR0 = 8'h10;
    localparam logic [7:0] OFS_MADDR0 = 8'h14;
    localparam logic [7:0] CHAN_STRIDE = 8'h14;
    localparam int FLAG_W = 4;
    localparam int FLAG_ANY = 0;
    localparam int FLAG_DONE = 1;
    localparam int FLAG_HALF = 2;
    localparam int FLAG_ERR = 3;
    localparam int CFG_W = 15;
    localparam int CFG_EN = 0;
    localparam int CFG_DONE_IE = 1;
    localparam int CFG_HALF_IE = 2;
    localparam int CFG_ERR_IE = 3;
    localparam int CFG_DIR = 4;
    localparam int CFG_CIRC = 5;
    localparam int CFG_PINC = 6;
    localparam int CFG_MINC = 7;
    localparam int CFG_PSIZE = 8;
    localparam int CFG_MEM_ITEM_SIZE = 10;
    localparam int CFG_PRIO = 12;
    localparam int CFG_M2M = 14;
    localparam int CNT_W = 16;
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;
    localparam logic [31:0] STEP_8 = 32'h1;
    localparam logic [31:0] STEP_16 = 32'h2;
    localparam logic [31:0] STEP_32 = 32'h4;
endpackage

// ===== tb_top.sv
// Self-checking bench of the DMA control block
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic clk, rst, reg_write, reg_read, xfer_ack, bus_error, xfer_valid, m2p, fail;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, src, dst;
    logic [6:0] periph_req, chan_irq;
    logic [2:0] xfer_chan;
    logic [1:0] ssize, dsize;
    logic [3:0] delay;
    int n_errors = 0;
    int tests_run = 0;
    row_s rows[6] = '{'{8'h08, 32'hffff_76fe, 32'h0000_76fe}, '{8'h08, 32'h0, 32'h0},
        '{8'h20, 32'hffff_1234, 32'h0000_1234}, '{8'h00, 32'hffff_ffff, 32'h0},
        '{8'hfc, 32'hffff_ffff, 32'h0}, '{8'h24, 32'h1234_5678, 32'h1234_5678}};
    dma_ctl i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .periph_req(periph_req), .xfer_ack(xfer_ack), .bus_error(bus_error),
        .xfer_valid(xfer_valid), .xfer_chan(xfer_chan), .xfer_mem_to_periph(m2p),
        .xfer_src_addr(src), .xfer_dst_addr(dst), .xfer_src_size(ssize),
        .xfer_dst_size(dsize), .chan_irq(chan_irq));
    bus_responder i_bus (.clk(clk), .rst(rst), .xfer_valid(xfer_valid), .delay(delay),
        .fail(fail), .xfer_ack(xfer_ack), .bus_error(bus_error));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask
    task automatic item(input logic [2:0] c, input logic [31:0] s, input logic [31:0] d);
        int k;
        k = 0;
        while (xfer_valid !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        chk({31'h0, xfer_valid}, 32'h1);
        chk({29'h0, xfer_chan}, {29'h0, c});
        chk(src, s);
        chk(dst, d);
        while (xfer_valid === 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done;
    end
    initial begin
        {rst, reg_write, reg_read, fail} = 4'h8;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        periph_req = 7'h0;
        delay = 4'h1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e, 32'hffff_ffff);
        end
        $display("register table done");
        // Mem-to-mem, 16-bit source and 32-bit destination steps
        wr(8'h10, 32'h100);
        wr(8'h14, 32'h200);
        wr(8'h0c, 32'h4);
        wr(8'h08, 32'h49cf);
        for (int i = 0; i < 4; i++) item(3'h0, 32'h100 + 2 * i, 32'h200 + 4 * i);
        rd(8'h00, 32'h7, 32'hf);
        chk({30'h0, ssize}, 32'h1);
        chk({30'h0, dsize}, 32'h2);
        chk({31'h0, m2p}, 32'h0);
        chk({31'h0, chan_irq[0]}, 32'h1);
        rd(8'h0c, 32'h0, 32'hffff_ffff);
        wr(8'h0c, 32'h9);
        rd(8'h0c, 32'h0, 32'hffff_ffff);
        chk({31'h0, xfer_valid}, 32'h0);
        wr(8'h04, 32'h0);
        rd(8'h00, 32'h7, 32'hf);
        wr(8'h04, 32'h4);
        rd(8'h00, 32'h3, 32'hf);
        wr(8'h04, 32'h2);
        rd(8'h00, 32'h1, 32'hf);
        chk({31'h0, chan_irq[0]}, 32'h0);
        $display("mem-to-mem done");
        // Bus error on a peripheral channel
        fail <= 1'b1;
        delay <= 4'h0;
        wr(8'h20, 32'h3);
        wr(8'h1c, 32'h9);
        periph_req <= 7'h02;
        item(3'h1, 32'h1234_5678, 32'h0);
        fail <= 1'b0;
        periph_req <= 7'h00;
        rd(8'h1c, 32'h8, 32'hffff_ffff);
        rd(8'h00, 32'h90, 32'hf0);
        chk({31'h0, chan_irq[1]}, 32'h1);
        wr(8'h04, 32'h80);
        rd(8'h00, 32'h10, 32'hf0);
        wr(8'h04, 32'h10);
        rd(8'h00, 32'h0, 32'hf0);
        $display("bus error done");
        // Three requesters, two sharing the top priority
        wr(8'h34, 32'h1);
        wr(8'h5c, 32'h1);
        wr(8'h70, 32'h1);
        wr(8'h30, 32'h11);
        wr(8'h58, 32'h2011);
        wr(8'h6c, 32'h2011);
        periph_req <= 7'h34;
        item(3'h4, 32'h0, 32'h0);
        @(negedge clk);
        chk({31'h0, m2p}, 32'h1);
        item(3'h5, 32'h0, 32'h0);
        item(3'h2, 32'h0, 32'h0);
        periph_req <= 7'h00;
        $display("priority done");
        // Circular byte channel with slow answers; request drops on the same edge as the last grant
        delay <= 4'h3;
        wr(8'h88, 32'h300);
        wr(8'h84, 32'h2);
        wr(8'h80, 32'h61);
        periph_req <= 7'h40;
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                periph_req <= 7'h00;
            end
            item(3'h6, 32'h300 + i % 2, 32'h0);
        end
        wr(8'h80, 32'h0);
        repeat (10) @(posedge clk);
        rd(8'h84, 32'h2, 32'hffff_ffff);
        rd(8'h00, 32'h0700_0000, 32'h0f00_0000);
        $display("circular done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h08, 32'h0, 32'hffff_ffff);
        rd(8'h84, 32'h0, 32'hffff_ffff);
        rd(8'h00, 32'h0, 32'hffff_ffff);
        chk({25'h0, chan_irq}, 32'h0);
        $display("reset done");
        test_done;
    end
endmodule
